// *** hdl/crc_pkg.sv ***
// Package for the comparator reference control block.
// Assumes APB with 32-bit data; each of three 8-bit registers in the low bits.
package crc_pkg;
  // Register byte offsets (chosen, word aligned)
  localparam logic [7:0] REF_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] REF_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] REF_PORT_OFFSET = 8'h08;
  // Control register field positions
  localparam int POWER_BIT = 7;
  localparam int PIN_DRIVE_BIT = 6;
  localparam int SPAN_BIT = 5;
  localparam int SOURCE_BIT = 4;
  localparam int LEVEL_MSB = 3;
  localparam int LEVEL_LSB = 0;
  // Reset values
  localparam logic [7:0] REF_CTRL_RESET = 8'h00;
  localparam logic [7:0] PORT_DIR_RESET = 8'hFF;
  // Comparator mode that routes the reference to both comparators
  localparam logic [2:0] CMP_MODE_FOUR_TO_TWO = 3'h6;
  // Ladder tap layout: low range uses taps 0..15 of a 24 step ladder,
  // high range starts 8 steps of 32 above the bottom
  localparam logic [5:0] HIGH_RANGE_BASE = 6'h08;
  // Ladder divisors; 32 needs six bits, so the divisor is six bits wide
  localparam logic [5:0] LOW_RANGE_DIV = 6'h18;
  localparam logic [5:0] HIGH_RANGE_DIV = 6'h20;
  // Reset state of the tap pair: high range, level code zero
  localparam logic [5:0] TAP_RESET = 6'h08;
  // Access phase encoding; the bus slave holds no state and does not use it
  typedef enum logic [0:0] {
    CRC_IDLE = 1'b0,
    CRC_ACCESS = 1'b1
  } crc_bus_e;
endpackage

// *** hdl/crc_apb_slave.sv ***
// APB slave front end: decodes three word registers, zero wait state.
// Assumes a standard APB master on pclk; unmapped reads return zero.
`timescale 1ns/1ps
module crc_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wr_ctrl,
  output logic wr_port,
  output logic [7:0] wr_data,
  input wire logic [7:0] ctrl_val,
  input wire logic [7:0] status_val,
  input wire logic [7:0] port_val
);
  // Access phase completes every transfer in its first cycle
  wire access = psel & penable;
  wire hit_ctrl = paddr == crc_pkg::REF_CTRL_OFFSET;
  wire hit_status = paddr == crc_pkg::REF_STATUS_OFFSET;
  wire hit_port = paddr == crc_pkg::REF_PORT_OFFSET;
  // Unmapped addresses answer with an error rather than hanging
  wire mapped = hit_ctrl | hit_status | hit_port;
  logic [7:0] rd_mux;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign wr_ctrl = access & pwrite & hit_ctrl;
  assign wr_port = access & pwrite & hit_port;
  assign wr_data = pwdata[7:0];
  // Read selection, upper bits zero
  assign rd_mux = hit_ctrl ? ctrl_val :
                  hit_status ? status_val :
                  hit_port ? port_val : 8'h00;
  assign prdata = access & ~pwrite ? {24'h000000, rd_mux} : 32'h00000000;
endmodule

// *** hdl/crc_pin_route.sv ***
// Pin multiplexer for port bit 2 and comparator reference routing.
// Assumes the analog pad interprets ref_to_pin as a switch closure.
`timescale 1ns/1ps
module crc_pin_route (
  input wire logic pin_drive,
  input wire logic port_dir_bit2,
  input wire logic [2:0] comparator_config,
  output logic ref_to_pin,
  output logic porta_bit2_digital_oe,
  output logic ref_to_comparators
);
  // Reference on the pin overrides the direction bit
  assign ref_to_pin = pin_drive;
  // Digital driver off while the reference owns the pin
  assign porta_bit2_digital_oe = ~pin_drive & ~port_dir_bit2;
  // Comparator inputs take the reference only in four-to-two mode
  assign ref_to_comparators =
    comparator_config == crc_pkg::CMP_MODE_FOUR_TO_TWO;
endmodule

// *** hdl/crc_top.sv ***
// Comparator reference control: register and ladder control outputs.
// Assumes APB on pclk; analog ladder consumes the outputs directly.
//
// Behaviour
// - Bit 7 set powers ladder, clear powers down
// - Bit 6 connects reference level to port pin
// - Pin drive overrides port direction bit two
// - Span bit one: level over 24 times span
// - Span bit zero: quarter span plus level/32
// - Source bit picks external pins or rails
// - Four-bit level code selects one of sixteen
// - Reset clears whole control register to zero
// - Register contents survive sleep and wake-up
// - Reference works regardless of comparator setup
// - Comparators get reference only in mode 110
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module crc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] comparator_config,
  output logic ref_power_on,
  output logic ref_source_select,
  output logic [5:0] ladder_tap,
  output logic [5:0] ladder_divisor,
  output logic ref_to_pin,
  output logic porta_bit2_digital_oe,
  output logic ref_to_comparators
);
  // Control register and port direction shadow
  logic [7:0] ref_ctrl_reg_q;
  logic [7:0] porta_direction_q;
  logic wr_ctrl;
  logic wr_port;
  logic [7:0] wr_data;
  logic [5:0] tap_d;
  logic [5:0] div_d;
  logic [5:0] tap_q;
  logic [5:0] div_q;
  logic [7:0] status_val;

  // Named fields of the control register
  wire ref_pin_drive = ref_ctrl_reg_q[crc_pkg::PIN_DRIVE_BIT];
  wire ref_span_select = ref_ctrl_reg_q[crc_pkg::SPAN_BIT];
  wire [3:0] ref_level_code =
    ref_ctrl_reg_q[crc_pkg::LEVEL_MSB:crc_pkg::LEVEL_LSB];

  // Bus front end
  crc_apb_slave u_bus (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wr_ctrl(wr_ctrl),
    .wr_port(wr_port),
    .wr_data(wr_data),
    .ctrl_val(ref_ctrl_reg_q),
    .status_val(status_val),
    .port_val(porta_direction_q)
  );

  // Control register: reset clears it, nothing else but a write alters it,
  // so sleep and wake-up leave it untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ctrl_reg_q <= crc_pkg::REF_CTRL_RESET;
    end else if (wr_ctrl) begin
      ref_ctrl_reg_q <= wr_data;
    end
  end

  // Port direction shadow, resets to all inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      porta_direction_q <= crc_pkg::PORT_DIR_RESET;
    end else if (wr_port) begin
      porta_direction_q <= wr_data;
    end
  end

  // Tap index and ladder divisor for the chosen range; level code is
  // passed as a tap so the ladder needs no arithmetic of its own
  assign tap_d = ref_span_select ? {2'b00, ref_level_code}
    : crc_pkg::HIGH_RANGE_BASE + {2'b00, ref_level_code};
  assign div_d = ref_span_select ? crc_pkg::LOW_RANGE_DIV
    : crc_pkg::HIGH_RANGE_DIV;

  // Registered so tap and divisor always move as a pair, no glitch
  // between the two on a range change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_q <= crc_pkg::TAP_RESET;
      div_q <= crc_pkg::HIGH_RANGE_DIV;
    end else begin
      tap_q <= tap_d;
      div_q <= div_d;
    end
  end

  // Field outputs and registered ladder pair; independent of comparator configuration
  assign ref_power_on = ref_ctrl_reg_q[crc_pkg::POWER_BIT];
  assign ref_source_select =
    ref_ctrl_reg_q[crc_pkg::SOURCE_BIT];
  assign ladder_tap = tap_q;
  assign ladder_divisor = div_q;
  // Status: routing and comparator mode as seen by the block
  assign status_val = {3'b000, ref_to_comparators, ref_to_pin,
                       comparator_config};

  // Pin and comparator routing
  crc_pin_route u_route (
    .pin_drive(ref_pin_drive),
    .port_dir_bit2(porta_direction_q[2]),
    .comparator_config(comparator_config),
    .ref_to_pin(ref_to_pin),
    .porta_bit2_digital_oe(porta_bit2_digital_oe),
    .ref_to_comparators(ref_to_comparators)
  );
endmodule

// *** tb/crc_ladder_model.sv ***
// Stand-in for the analog ladder: level in per mille of the span.
// Assumes tap and divisor come straight from crc_top.
`timescale 1ns/1ps
module crc_ladder_model (
  input wire logic power_on,
  input wire logic [5:0] tap,
  input wire logic [5:0] divisor,
  output logic [15:0] level_permille
);
  // Unpowered ladder gives zero; integer division floors like a tap
  always_comb begin
    level_permille = power_on ? 16'(tap * 1000 / divisor) : 16'h0000;
  end
endmodule

// *** tb/crc_top_chk.sv ***
// Concurrent checks on the ports of crc_top.
// Assumes the bind below; one clock domain.
`timescale 1ns/1ps
module crc_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] comparator_config,
  input wire logic ref_power_on,
  input wire logic ref_source_select,
  input wire logic [5:0] ladder_tap,
  input wire logic [5:0] ladder_divisor,
  input wire logic ref_to_pin,
  input wire logic ref_to_comparators
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control write completing at this edge
  wire logic wr = psel && penable && pwrite && paddr == 8'h00;
  wire logic [7:0] wd = pwdata[7:0];
  a_power_write:
    assert property (wr |=> ref_power_on == $past(wd[7])) else $error("pwr");
  a_pin_write:
    assert property (wr |=> ref_to_pin == $past(wd[6])) else $error("pin");
  a_source_write:
    assert property (wr |=> ref_source_select == $past(wd[4]))
      else $error("source");
  a_span_write:
    assert property (wr |=> ##1 ladder_divisor == ($past(wd[5], 2) ?
      6'd24 : 6'd32)) else $error("span");
  a_low_taps:
    assert property (ladder_divisor == 6'd24 |-> ladder_tap < 6'd16)
      else $error("low tap");
  a_high_taps:
    assert property (ladder_divisor == 6'd32 |-> ladder_tap inside {[8:23]})
      else $error("high tap");
  a_cmp_route:
    assert property (ref_to_comparators == (comparator_config == 3'h6))
      else $error("cmp");
  a_hold_idle:
    assert property (!wr |=> $stable({ref_power_on, ref_to_pin}))
      else $error("hold");
  c_low: cover property (wr && wd[5]);
  c_pin: cover property (ref_to_pin);
  c_cmp: cover property (ref_to_comparators);
endmodule
bind crc_top crc_top_chk crc_top_chk_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .comparator_config, .ref_power_on,
  .ref_source_select, .ladder_tap, .ladder_divisor, .ref_to_pin,
  .ref_to_comparators);

// *** tb/test_comparator_reference_control.sv ***
// Self-checking bench: APB accesses, ladder model, pin routing.
// Assumes crc_top, its checker bind and crc_ladder_model.
`timescale 1ns/1ps
module test_comparator_reference_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, err, ref_power_on, ref_source_select, ref_to_pin;
  logic porta_bit2_digital_oe, ref_to_comparators;
  logic [2:0] comparator_config = 3'h0;
  logic [5:0] ladder_tap;
  logic [5:0] ladder_divisor;
  logic [15:0] level_permille;
  int failures = 0, samples_checked = 0;
  initial forever #2 pclk = ~pclk;
  crc_top crc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .comparator_config, .ref_power_on,
    .ref_source_select, .ladder_tap, .ladder_divisor, .ref_to_pin,
    .porta_bit2_digital_oe, .ref_to_comparators);
  crc_ladder_model crc_ladder_model_inst (.power_on(ref_power_on),
    .tap(ladder_tap), .divisor(ladder_divisor), .level_permille);
  task automatic chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer; request held until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Tap and divisor land one edge after the register
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic complete_run;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #40000;
    failures++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, 8'h00, 0);
    chk(rd, 32'h0);
    settle;
    chk({ref_power_on, ref_to_pin, ladder_divisor}, 8'h20);
    chk(ladder_tap, 8);
    $display("reset test done");
    // Every level code in both ranges, external source, powered
    for (int i = 0; i < 32; i++) begin
      xfer(1, 8'h00, {24'h0, 2'b10, i[4], 1'b1, i[3:0]});
      settle;
      chk(ladder_tap, i[4] ? i[3:0] : i[3:0] + 8);
      chk(level_permille, i[4] ? i[3:0] * 1000 / 24 :
        250 + i[3:0] * 1000 / 32);
      chk({ref_power_on, ref_source_select}, 2'b11);
    end
    $display("level test done");
    // Direction set to output; pin drive must override it
    xfer(1, 8'h08, 0);
    for (int p = 0; p < 2; p++) begin
      xfer(1, 8'h00, p ? 32'h40 : 32'h00);
      settle;
      // Power stays off here, as software leaves it before sleep
      chk({ref_power_on, ref_to_pin, porta_bit2_digital_oe},
        p ? 3'b010 : 3'b001);
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge pclk);
      comparator_config <= c[2:0];
      settle;
      chk({ref_to_comparators, ref_to_pin}, {c == 6, 1'b1});
    end
    xfer(1, 8'h0C, 32'hFF);
    xfer(0, 8'h0C, 0);
    chk({31'h0, err}, 1);
    chk(rd, 32'h0);
    xfer(0, 8'h04, 0);
    chk(rd, 32'h0F);
    xfer(0, 8'h00, 0);
    chk(rd, 32'h40);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, 8'h00, 0);
    chk(rd, 32'h0);
    $display("pin and reset test done");
    complete_run;
  end
endmodule
